// ===== rtl/tmin_top.sv
// Operation
// RL1 - Input modes need second prescaler bit1 zero
// RL2 - Mode bits 5:4 pick input function
// RL3 - Software selects external source first
// RL4 - Software enables count bit before counting
// RL5 - Software loads gated/event; device loads triggered
// RL6 - Every pin falling edge raises request two
// RL7 - Event mode: falling edge clocks chain
// RL8 - Gated mode: timer clock only while high
// RL9 - Gated: edge gives request two, end five
// RL10 - Triggered: first edge loads and starts
// RL11 - Triggered single pass clears enable at end
// RL12 - Triggered continuous runs until enable cleared
// RL13 - Retrigger: each enabled edge reloads timer
// RL14 - Retrigger single pass clears enable, ignores edges
// RL15 - Retrigger continuous: request five each end
// RL16 - Cascade via toggle output into input
// RL17 - Reset: disabled, single pass, external, event
// RL18 - Six interrupts gated by master bit7; here the three requests leave ungated and bit7 only drives master_enable
// RL19 - Pin preferably configured as plain input
// RL20 - Prescaler bit0: single pass or continuous
// RL21 - Load copies initials, clears itself next clock
// RL22 - Pin synchronised before falling edge detection
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tmin_top (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  input  wire logic       timer_input_pin,
  input  wire logic       disable_interrupts_instr,
  input  wire logic       enable_interrupts_instr,
  output var  logic       toggle_out,
  output var  logic       input_edge_request,
  output var  logic       first_counter_request,
  output var  logic       second_counter_request,
  output var  logic       master_enable
);
  import tmin_pkg::*;

  typedef struct packed {
    logic [2:0] pin_sync;
    logic [7:0] mode;
    logic [7:0] second_prescaler_setup;
    logic [7:0] first_prescaler_setup;
    logic [7:0] init1;
    logic [7:0] init0;
    logic [7:0] mask;
    logic [1:0] tdiv;
    logic       trig_run;
    logic       tog;
    logic       req2;
    logic       req4;
    logic       req5;
    logic [7:0] rdata;
  } tmin_state_t;

  tmin_state_t st;
  tmin_state_t next_st;

  logic         fall;
  logic         tclk;
  logic         in_active;
  tmin_inmode_t inmode;
  logic         load1;
  logic         load0;
  logic         tick1;
  logic         tick0;
  logic         eoc1;
  logic         eoc0;
  logic [7:0]   count1;
  logic [7:0]   count0;
  logic         en1;
  logic         wr_mode;

  // ---------------------------------------------------------------
  // Input pin conditioning
  // ---------------------------------------------------------------
  // Stage 2 is the registered copy used for edges; stage 0 feeds only stage 1
  assign fall = st.pin_sync[2] & ~st.pin_sync[1]; // [RL22]
  assign tclk = (st.tdiv == TMIN_TDIV_LAST);

  assign inmode    = tmin_inmode_t'(st.mode[TMIN_MODE_IN_HI:TMIN_MODE_IN_LO]); // [RL2]
  assign in_active = st.second_prescaler_setup[TMIN_PRE_EXTCLK] & ~st.second_prescaler_setup[TMIN_PRE_INMODE]; // [RL1]
  assign en1       = st.mode[TMIN_MODE_EN1];
  assign wr_mode   = wr && (addr == TMIN_ADDR_MODE);

  // ---------------------------------------------------------------
  // Second and first timer clocking
  // ---------------------------------------------------------------
  always_comb begin
    load1 = st.mode[TMIN_MODE_LOAD1]; // [RL5]
    tick1 = 1'b0;
    if (!st.second_prescaler_setup[TMIN_PRE_EXTCLK]) begin
      tick1 = en1 & tclk;
    end else if (in_active && en1) begin
      unique case (inmode)
        TMIN_IN_EVENT: tick1 = fall; // [RL7]
        TMIN_IN_GATED: tick1 = tclk & st.pin_sync[1]; // [RL8]
        TMIN_IN_TRIG: begin
          tick1 = st.trig_run & tclk;
          if (fall && !st.trig_run) begin
            load1 = 1'b1; // [RL10] [RL5]
          end
        end
        TMIN_IN_RETRG: begin
          tick1 = st.trig_run & tclk;
          if (fall) begin
            load1 = 1'b1; // [RL13] [RL5]
          end
        end
      endcase
    end
  end

  assign load0 = st.mode[TMIN_MODE_LOAD0];
  assign tick0 = st.mode[TMIN_MODE_EN0] & tclk;

  tmin_chain u_second (
    .clk      (clk),
    .arst_n   (arst_n),
    .load     (load1),
    .tick     (tick1),
    .cont     (st.second_prescaler_setup[TMIN_PRE_CONT]),
    .pre_init (st.second_prescaler_setup[7:2]),
    .cnt_init (st.init1),
    .count    (count1),
    .eoc      (eoc1)
  );

  tmin_chain u_first (
    .clk      (clk),
    .arst_n   (arst_n),
    .load     (load0),
    .tick     (tick0),
    .cont     (st.first_prescaler_setup[TMIN_PRE_CONT]),
    .pre_init (st.first_prescaler_setup[7:2]),
    .cnt_init (st.init0),
    .count    (count0),
    .eoc      (eoc0)
  );

  // ---------------------------------------------------------------
  // State update
  // ---------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.pin_sync = {st.pin_sync[1:0], timer_input_pin};
    next_st.tdiv     = st.tdiv + 2'h1;
    next_st.rdata    = TMIN_ZERO8;
    next_st.req2     = fall; // [RL6] [RL9]
    next_st.req4     = eoc0;
    next_st.req5     = eoc1; // [RL9] [RL15]
    // Load bits clear on the following clock
    next_st.mode[TMIN_MODE_LOAD0] = 1'b0; // [RL21]
    next_st.mode[TMIN_MODE_LOAD1] = 1'b0; // [RL21]
    if (load1) begin
      next_st.trig_run = 1'b1;
    end
    if (!en1) begin
      next_st.trig_run = 1'b0;
    end
    if (eoc1 && !st.second_prescaler_setup[TMIN_PRE_CONT]) begin
      // Single pass drops the enable, so later edges are ignored
      next_st.mode[TMIN_MODE_EN1] = 1'b0; // [RL11] [RL14]
      next_st.trig_run = 1'b0;
    end
    // Toggle output flips on the selected timer's end of count
    if ((st.mode[TMIN_MODE_OUT_HI:TMIN_MODE_OUT_LO] == 2'b01 && eoc0) ||
        (st.mode[TMIN_MODE_OUT_HI:TMIN_MODE_OUT_LO] == 2'b10 && eoc1)) begin
      next_st.tog = ~st.tog;
    end
    if (disable_interrupts_instr) begin
      next_st.mask[TMIN_MASK_MASTER] = 1'b0; // [RL18]
    end else if (enable_interrupts_instr) begin
      next_st.mask[TMIN_MASK_MASTER] = 1'b1; // [RL18]
    end
    if (wr) begin
      unique case (addr)
        TMIN_ADDR_MODE: begin
          next_st.mode = wdata;
          // A same-cycle rewrite of the enable bit wins over the hardware clear
          if (eoc1 && !st.second_prescaler_setup[TMIN_PRE_CONT] && st.mode[TMIN_MODE_EN1]) begin
            next_st.mode[TMIN_MODE_EN1] = wdata[TMIN_MODE_EN1];
          end
          if (!wdata[TMIN_MODE_EN1]) begin
            next_st.trig_run = 1'b0; // [RL12]
          end
          if (wdata[TMIN_MODE_LOAD0] || wdata[TMIN_MODE_OUT_HI:TMIN_MODE_OUT_LO]
              != st.mode[TMIN_MODE_OUT_HI:TMIN_MODE_OUT_LO]) begin
            next_st.tog = 1'b1;
          end
        end
        TMIN_ADDR_SECOND_PRE:    next_st.second_prescaler_setup  = wdata;
        TMIN_ADDR_FIRST_PRE:     next_st.first_prescaler_setup  = wdata;
        TMIN_ADDR_SECOND_COUNTER: next_st.init1 = wdata;
        TMIN_ADDR_FIRST_COUNTER: next_st.init0 = wdata;
        TMIN_ADDR_INT_MASK:      next_st.mask  = wdata;
        default: ;
      endcase
    end
    if (rd) begin
      unique case (addr)
        TMIN_ADDR_MODE:           next_st.rdata = st.mode;
        TMIN_ADDR_SECOND_COUNTER: next_st.rdata = count1;
        TMIN_ADDR_FIRST_COUNTER:  next_st.rdata = count0;
        TMIN_ADDR_INT_MASK:       next_st.rdata = st.mask;
        default:                  next_st.rdata = TMIN_ZERO8;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st       <= '0;
      st.mode  <= TMIN_MODE_RST;  // [RL17]
      st.second_prescaler_setup  <= TMIN_SECOND_PRESCALER_SETUP_RST;  // [RL17]
      st.first_prescaler_setup  <= TMIN_FIRST_PRESCALER_SETUP_RST;  // [RL17]
      st.mask  <= TMIN_MASK_RST;
      st.tog   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata                  = st.rdata;
  assign toggle_out             = st.tog;
  assign input_edge_request     = st.req2;
  assign first_counter_request  = st.req4;
  assign second_counter_request = st.req5;
  assign master_enable          = st.mask[TMIN_MASK_MASTER];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_EDGE_REQ: assert property (@(posedge clk) disable iff (!arst_n) // [RL6]
    (st.pin_sync[2] && !st.pin_sync[1]) |=> input_edge_request)
    else $error("Falling edge gave no request two");
  AST_EOC_REQ: assert property (@(posedge clk) disable iff (!arst_n) // [RL9]
    eoc1 |=> second_counter_request)
    else $error("End of count gave no request five");
  AST_LOAD_SELF_CLEAR: assert property (@(posedge clk) disable iff (!arst_n) // [RL21]
    (st.mode[TMIN_MODE_LOAD1] && !wr_mode) |=> !st.mode[TMIN_MODE_LOAD1])
    else $error("Load bit did not clear itself");
  AST_SINGLE_CLEAR_EN: assert property (@(posedge clk) disable iff (!arst_n) // [RL11]
    (eoc1 && !st.second_prescaler_setup[TMIN_PRE_CONT] && !wr_mode) |=> !st.mode[TMIN_MODE_EN1])
    else $error("Single pass end kept enable set");
  AST_GATE_LOW: assert property (@(posedge clk) disable iff (!arst_n) // [RL8]
    (st.second_prescaler_setup[TMIN_PRE_EXTCLK] && in_active && inmode == TMIN_IN_GATED && !st.pin_sync[1])
      |-> !tick1)
    else $error("Gated timer ticked with pin low");
  AST_EVENT_TICK: assert property (@(posedge clk) disable iff (!arst_n) // [RL7]
    (st.second_prescaler_setup[TMIN_PRE_EXTCLK] && in_active && en1 && inmode == TMIN_IN_EVENT)
      |-> (tick1 == fall))
    else $error("Event mode tick not tied to edge");
  AST_TRIG_ONCE: assert property (@(posedge clk) disable iff (!arst_n) // [RL10]
    (in_active && inmode == TMIN_IN_TRIG && st.trig_run && fall
      && !st.mode[TMIN_MODE_LOAD1]) |-> !load1)
    else $error("Later edge reloaded triggered timer");
  AST_RETRIG_LOAD: assert property (@(posedge clk) disable iff (!arst_n) // [RL13]
    (st.second_prescaler_setup[TMIN_PRE_EXTCLK] && in_active && en1 && inmode == TMIN_IN_RETRG && fall)
      |-> load1)
    else $error("Retrigger edge did not reload");
  AST_DI: assert property (@(posedge clk) disable iff (!arst_n) // [RL18]
    disable_interrupts_instr |=> !master_enable)
    else $error("Disable instruction kept master enable");
  AST_INMODE_OFF: assert property (@(posedge clk) disable iff (!arst_n) // [RL1]
    (st.second_prescaler_setup[TMIN_PRE_INMODE] && !st.mode[TMIN_MODE_LOAD1]) |-> !load1)
    else $error("Input mode acted with bit1 set");

  COV_EVENT: cover property (@(posedge clk) disable iff (!arst_n)
    inmode == TMIN_IN_EVENT && tick1);
  COV_TRIG: cover property (@(posedge clk) disable iff (!arst_n)
    inmode == TMIN_IN_TRIG && fall && load1);
  COV_RETRIG_EOC: cover property (@(posedge clk) disable iff (!arst_n)
    inmode == TMIN_IN_RETRG && eoc1);
  COV_GATED_EOC: cover property (@(posedge clk) disable iff (!arst_n)
    inmode == TMIN_IN_GATED && eoc1);
endmodule
`default_nettype wire

// ===== pkg/tmin_pkg.sv
package tmin_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] TMIN_ADDR_SECOND_COUNTER = 8'hf2;
  localparam logic [7:0] TMIN_ADDR_MODE           = 8'hf1;
  localparam logic [7:0] TMIN_ADDR_SECOND_PRE     = 8'hf3;
  localparam logic [7:0] TMIN_ADDR_FIRST_COUNTER  = 8'hf4;
  localparam logic [7:0] TMIN_ADDR_FIRST_PRE      = 8'hf5;
  localparam logic [7:0] TMIN_ADDR_INT_MASK       = 8'hfb;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TMIN_MODE_LOAD0  = 0;
  localparam int TMIN_MODE_EN0    = 1;
  localparam int TMIN_MODE_LOAD1  = 2;
  localparam int TMIN_MODE_EN1    = 3;
  localparam int TMIN_MODE_IN_LO  = 4;
  localparam int TMIN_MODE_IN_HI  = 5;
  localparam int TMIN_MODE_OUT_LO = 6;
  localparam int TMIN_MODE_OUT_HI = 7;
  localparam int TMIN_PRE_CONT    = 0;
  localparam int TMIN_PRE_INMODE  = 1;
  localparam int TMIN_PRE_EXTCLK  = 2;
  localparam int TMIN_MASK_MASTER = 7;
  localparam int TMIN_NUM_IRQ     = 6;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] TMIN_MODE_RST  = 8'h00;
  localparam logic [7:0] TMIN_SECOND_PRESCALER_SETUP_RST  = 8'h04;
  localparam logic [7:0] TMIN_FIRST_PRESCALER_SETUP_RST  = 8'h00;
  localparam logic [7:0] TMIN_MASK_RST  = 8'h00;
  localparam logic [5:0] TMIN_PS_ONE    = 6'h01;
  localparam logic [7:0] TMIN_CNT_ONE   = 8'h01;
  localparam logic [7:0] TMIN_ZERO8     = 8'h00;
  localparam logic [1:0] TMIN_TDIV_LAST = 2'h3;

  typedef enum logic [1:0] {
    TMIN_IN_EVENT = 2'b00,
    TMIN_IN_GATED = 2'b01,
    TMIN_IN_TRIG  = 2'b10,
    TMIN_IN_RETRG = 2'b11
  } tmin_inmode_t;
endpackage

// ===== rtl/tmin_chain.sv
`timescale 1ns/1ps
`default_nettype none
module tmin_chain (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       load,
  input  wire logic       tick,
  input  wire logic       cont,
  input  wire logic [5:0] pre_init,
  input  wire logic [7:0] cnt_init,
  output var  logic [7:0] count,
  output var  logic       eoc
);
  import tmin_pkg::*;

  typedef struct packed {
    logic [5:0] ps;
    logic [7:0] cnt;
    logic       rest;
    logic       eoc;
  } tmin_chain_t;

  tmin_chain_t st;
  tmin_chain_t next_st;

  // ---------------------------------------------------------------
  // Prescaler and down-counter
  // ---------------------------------------------------------------
  // Prescaler reloads at one, so a six-bit init of zero means 64; an eight-bit init of zero means 256
  always_comb begin
    next_st     = st;
    next_st.eoc = 1'b0;
    if (load) begin
      next_st.ps   = pre_init; // [RL21]
      next_st.cnt  = cnt_init; // [RL21]
      next_st.rest = 1'b0;
    end else if (tick && !st.rest) begin
      if (st.ps == TMIN_PS_ONE) begin
        next_st.ps = pre_init;
        if (st.cnt == TMIN_CNT_ONE) begin
          next_st.eoc = 1'b1;
          if (cont) begin
            next_st.cnt = cnt_init; // [RL20]
          end else begin
            next_st.cnt  = TMIN_ZERO8; // [RL20]
            next_st.rest = 1'b1;
          end
        end else begin
          next_st.cnt = st.cnt - TMIN_CNT_ONE;
        end
      end else begin
        next_st.ps = st.ps - TMIN_PS_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.cnt;
  assign eoc   = st.eoc;

  AST_SINGLE_REST: assert property (@(posedge clk) disable iff (!arst_n) // [RL20]
    (eoc && !cont && !$past(cont) && !load) |-> (count == TMIN_ZERO8))
    else $error("Single pass did not rest at zero");
endmodule
`default_nettype wire

// ===== dv/tmin_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmin_pin_model (
  input  wire logic clk,
  input  wire logic follow,
  input  wire logic toggle_src,
  output var  logic pin
);
  logic level;

  // ---------------------------------------------------------------
  // Pin source
  // ---------------------------------------------------------------
  // Plain input line, idles high
  initial level = 1'b1;
  // Toggle output wired back to the pin when cascading
  assign pin = follow ? toggle_src : level;

  task automatic set_level(input logic v);
    @(posedge clk);
    level <= v;
  endtask

  // Phases of 8 cycles so the synchroniser never misses a level
  task automatic fall();
    set_level(1'b0);
    repeat (7) @(posedge clk);
    set_level(1'b1);
    repeat (7) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tmin_pkg::*;
  logic       clk;
  logic       arst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       pin;
  logic       di_instr;
  logic       ei_instr;
  logic       follow;
  logic       toggle_out;
  logic       edge_req;
  logic       eoc0_req;
  logic       eoc1_req;
  logic       master_enable;
  int         n_fail;
  int         n_compared;
  int         n_edge;
  int         n_eoc0;
  int         n_eoc1;
  int         cycles;

  // ---------------------------------------------------------------
  // Clock, design and pin partner
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  tmin_top dut (
    .clk                      (clk),
    .arst_n                   (arst_n),
    .addr                     (addr),
    .wdata                    (wdata),
    .wr                       (wr),
    .rd                       (rd),
    .rdata                    (rdata),
    .timer_input_pin          (pin),
    .disable_interrupts_instr (di_instr),
    .enable_interrupts_instr  (ei_instr),
    .toggle_out               (toggle_out),
    .input_edge_request       (edge_req),
    .first_counter_request    (eoc0_req),
    .second_counter_request   (eoc1_req),
    .master_enable            (master_enable)
  );

  tmin_pin_model u_pin (
    .clk        (clk),
    .follow     (follow),
    .toggle_src (toggle_out),
    .pin        (pin)
  );

  // ---------------------------------------------------------------
  // Pulse counters and hang guard
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (edge_req === 1'b1) n_edge <= n_edge + 1;
    if (eoc0_req === 1'b1) n_eoc0 <= n_eoc0 + 1;
    if (eoc1_req === 1'b1) n_eoc1 <= n_eoc1 + 1;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk8(rdata, exp);
  endtask

  // Prescaler first, then counter, then mode with enable
  task automatic setup(input logic [7:0] pre, input logic [7:0] cnt, input logic [7:0] mode);
    wr_reg(TMIN_ADDR_SECOND_PRE, pre);
    wr_reg(TMIN_ADDR_SECOND_COUNTER, cnt);
    wr_reg(TMIN_ADDR_MODE, mode);
  endtask

  task automatic run(input int edges, input int cyc, output int q);
    int s;
    s = n_eoc1;
    repeat (edges) u_pin.fall();
    repeat (cyc) @(posedge clk);
    q = n_eoc1 - s;
  endtask

  task automatic pulse_instr(input logic d, input logic e);
    @(posedge clk);
    di_instr <= d;
    ei_instr <= e;
    @(posedge clk);
    di_instr <= 1'b0;
    ei_instr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    int q;
    int s_g;
    int s_0;
    addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0; arst_n = 1'b0;
    di_instr = 1'b0; ei_instr = 1'b0; follow = 1'b0;
    n_fail = 0; n_compared = 0; n_edge = 0; n_eoc0 = 0; n_eoc1 = 0; cycles = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(TMIN_ADDR_MODE, TMIN_MODE_RST);
    rd_chk(TMIN_ADDR_SECOND_PRE, 8'h00);
    rd_chk(8'h10, 8'h00);
    chk8({7'h00, toggle_out}, 8'h01);
    chk8({7'h00, master_enable}, 8'h00);
    pulse_instr(1'b0, 1'b1);
    chk8({7'h00, master_enable}, 8'h01);
    pulse_instr(1'b1, 1'b1);
    chk8({7'h00, master_enable}, 8'h00);
    // Mask register written directly also drives the master enable
    wr_reg(TMIN_ADDR_INT_MASK, 8'h85);
    rd_chk(TMIN_ADDR_INT_MASK, 8'h85);
    chk8({7'h00, master_enable}, 8'h01);
    // Event clock, single pass: three edges reach end of count
    setup(8'h04, 8'h03, 8'h0c);
    rd_chk(TMIN_ADDR_MODE, 8'h08);
    s_g = n_edge;
    run(2, 10, q);
    chkn(q, 0);
    run(1, 10, q);
    chkn(q, 1);
    chkn(n_edge - s_g, 3);
    rd_chk(TMIN_ADDR_SECOND_COUNTER, 8'h00);
    run(2, 10, q);
    chkn(q, 0);
    // Gated: low pin holds the count
    u_pin.set_level(1'b0);
    setup(8'h04, 8'h02, 8'h1c);
    run(0, 100, q);
    chkn(q, 0);
    u_pin.set_level(1'b1);
    run(0, 60, q);
    chkn(q, 1);
    s_g = n_edge;
    u_pin.set_level(1'b0);
    repeat (10) @(posedge clk);
    chkn(n_edge - s_g, 1);
    u_pin.set_level(1'b1);
    // Triggered single pass
    setup(8'h04, 8'h02, 8'h28);
    run(0, 60, q);
    chkn(q, 0);
    run(1, 50, q);
    chkn(q, 1);
    rd_chk(TMIN_ADDR_MODE, 8'h20);
    run(1, 50, q);
    chkn(q, 0);
    // Bit1 of the second prescaler set: pin edges must not trigger
    setup(8'h06, 8'h02, 8'h28);
    run(1, 50, q);
    chkn(q, 0);
    // Triggered continuous
    setup(8'h05, 8'h02, 8'h28);
    run(1, 100, q);
    chkn(int'(q >= 2), 1);
    wr_reg(TMIN_ADDR_MODE, 8'h20);
    run(0, 10, q);
    run(0, 60, q);
    chkn(q, 0);
    // Retrigger continuous: edges closer than the interval
    setup(8'h05, 8'h08, 8'h38);
    run(4, 0, q);
    chkn(q, 0);
    run(0, 60, q);
    chkn(int'(q >= 1), 1);
    run(0, 40, q);
    chkn(int'(q >= 1), 1);
    wr_reg(TMIN_ADDR_MODE, 8'h30);
    // Retrigger single pass
    setup(8'h04, 8'h02, 8'h38);
    run(1, 50, q);
    chkn(q, 1);
    rd_chk(TMIN_ADDR_MODE, 8'h30);
    run(1, 50, q);
    chkn(q, 0);
    // Cascade: first timer toggles the pin of the second
    wr_reg(TMIN_ADDR_FIRST_PRE, 8'h05);
    wr_reg(TMIN_ADDR_FIRST_COUNTER, 8'h02);
    follow <= 1'b1;
    s_0 = n_eoc0;
    setup(8'h04, 8'h02, 8'h4f);
    run(0, 120, q);
    chkn(q, 1);
    chkn(int'(n_eoc0 - s_0 >= 4), 1);
    // Internal source, second timer drives the toggle output, single pass
    setup(8'h08, 8'h01, 8'h8c);
    run(0, 40, q);
    chkn(q, 1);
    chk8({7'h00, toggle_out}, 8'h00);
    run(0, 40, q);
    chkn(q, 0);
    complete_run();
  end
endmodule
`default_nettype wire
